// ---- pkg/gtc_pkg.sv ----
package gtc_pkg;
   localparam int unsigned count_width = 16;
   localparam int unsigned byte_width = 8;
   localparam logic [15:0] count_reset = 16'h0000;
   localparam logic [15:0] count_one = 16'h0001;
   localparam logic [15:0] count_four = 16'h0004;
   localparam logic [1:0] instr_div_last = 2'h3;
   localparam logic [1:0] phase_reset = 2'h0;

   typedef enum logic [1:0] {
      gtc_src_instr = 2'b00,
      gtc_src_sys = 2'b01,
      gtc_src_ext = 2'b10,
      gtc_src_rsvd = 2'b11
   } gtc_src_t;

   typedef struct packed {
      logic run_enable;
      logic gate_enable;
      gtc_src_t clock_source_select;
      logic secondary_osc_enable;
      logic ext_sync_enable;
   } gtc_ctrl_t;

   typedef struct packed {
      logic wr_high;
      logic wr_low;
      logic [7:0] wdata;
   } gtc_wr_t;

   typedef struct packed {
      logic sync_ff1;
      logic sync_ff2;
      logic prev_level;
   } gtc_sync_t;

   typedef struct packed {
      logic [15:0] count;
      logic [1:0] phase;
      logic armed;
      logic prev_run;
   } gtc_state_t;
endpackage

// ---- hdl/gtc_edge_sync.sv ----
`timescale 1ns/1ns
module gtc_edge_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   input wire logic bypass,
   output logic level,
   output logic rise,
   output logic fall
);
   gtc_pkg::gtc_sync_t s_q;
   gtc_pkg::gtc_sync_t s_d;
   logic cur;

   // bypass: pin treated as already clocked by the source, no extra stages
   assign cur = bypass ? pin : s_q.sync_ff2;
   assign level = cur;
   assign rise = cur & ~s_q.prev_level;
   assign fall = ~cur & s_q.prev_level;

   always_comb begin
      s_d = s_q;
      s_d.sync_ff1 = pin; // RULE_11
      s_d.sync_ff2 = s_q.sync_ff1; // RULE_11
      s_d.prev_level = cur;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- hdl/gtc_timer.sv ----
// Contract
// [RULE_01] count is a 16-bit up-only register, accessed as high and low bytes
// [RULE_02] writing either count byte loads it into the counter at once
// [RULE_03] off when run is 0; gate enable makes counting wait on gate
// [RULE_04] select 01 system clock, 00 instruction clock, 10 pin or oscillator
// [RULE_05] any oscillator enable starts the shared oscillator and selects it here
// [RULE_06] internal source makes a timer advancing once per instruction cycle
// [RULE_07] system clock source adds four per instruction cycle
// [RULE_08] external pin counts rising edges, synchronized or asynchronous
// [RULE_09] counter mode needs a falling edge after enable, write or disable
// [RULE_10] gate accepts asynchronous sources: gate pin or comparator outputs
// [RULE_11] synchronized external input passes a two-stage synchronizer
`timescale 1ns/1ns
module gtc_timer #(
   parameter int unsigned width = gtc_pkg::count_width
) (
   input wire logic clk,
   input wire logic reset,
   input gtc_pkg::gtc_ctrl_t ctrl,
   input gtc_pkg::gtc_wr_t wr,
   input wire logic external_clock_pin,
   input wire logic secondary_osc_clock,
   input wire logic gate_pin,
   input wire logic comp1_out,
   input wire logic comp2_out,
   input wire logic [1:0] gate_source_select,
   input wire logic gate_polarity,
   output logic [7:0] count_high_byte,
   output logic [7:0] count_low_byte,
   output logic secondary_osc_request,
   output logic counting
);
   gtc_pkg::gtc_state_t st_q;
   gtc_pkg::gtc_state_t st_d;
   logic ext_src;
   logic ext_level;
   logic ext_rise;
   logic ext_fall;
   logic gate_level;
   logic gate_raw;
   logic gate_ok;
   logic instr_tick;
   // helper nets between the decode functions and the state update
   logic gate_in;
   logic run_rise;
   logic load_any;
   logic step_en;
   logic [15:0] loaded;

   // gate source codes; 0 and 3 both take the gate pin
   localparam logic [1:0] gate_sel_comp1 = 2'h1;
   localparam logic [1:0] gate_sel_comp2 = 2'h2;
   localparam logic [1:0] phase_step = 2'h1;

   // one count step; there is no down or reload path, only byte writes
   function automatic logic [15:0] count_step(
      input logic [15:0] value
   );
      count_step = value + gtc_pkg::count_one; // RULE_01
   endfunction

   // free-running divide by four that marks the instruction cycle
   function automatic logic last_phase(
      input logic [1:0] phase
   );
      last_phase = (phase == gtc_pkg::instr_div_last); // RULE_06
   endfunction

   // step enable per source; the reserved code never steps
   function automatic logic source_step(
      input gtc_pkg::gtc_src_t src,
      input logic instr,
      input logic rise,
      input logic armed
   );
      unique case (src)
         gtc_pkg::gtc_src_sys: begin
            // every system clock, so four per instruction cycle
            source_step = 1'b1; // RULE_04 RULE_07
         end
         gtc_pkg::gtc_src_instr: begin
            source_step = instr; // RULE_04 RULE_06
         end
         gtc_pkg::gtc_src_ext: begin
            source_step = rise & armed; // RULE_04 RULE_08 RULE_09
         end
         gtc_pkg::gtc_src_rsvd: begin
            source_step = 1'b0;
         end
      endcase
   endfunction

   // byte writes land directly in the counter, no staging latch between the halves
   function automatic logic [15:0] load_bytes(
      input logic [15:0] value,
      input gtc_pkg::gtc_wr_t w
   );
      load_bytes = value;
      if (w.wr_high) begin
         load_bytes[15:8] = w.wdata; // RULE_02
      end
      if (w.wr_low) begin
         load_bytes[7:0] = w.wdata; // RULE_02
      end
   endfunction

   // arming: a falling edge sets it; run off, a fresh enable or a write clears it
   function automatic logic arm_next(
      input logic armed,
      input logic fall,
      input logic run,
      input logic run_edge,
      input logic load
   );
      arm_next = armed;
      if (fall) begin
         arm_next = 1'b1; // RULE_09
      end
      if (!run || run_edge || load) begin
         arm_next = 1'b0; // RULE_09
      end
   endfunction

   // gate mux; select codes outside the comparator pair fall back to the pin
   function automatic logic gate_pick(
      input logic [1:0] sel,
      input logic pin,
      input logic c1,
      input logic c2
   );
      if (sel == gate_sel_comp1) begin
         gate_pick = c1; // RULE_10
      end else if (sel == gate_sel_comp2) begin
         gate_pick = c2; // RULE_10
      end else begin
         gate_pick = pin; // RULE_10
      end
   endfunction

   // one readable half of the count
   function automatic logic [7:0] count_byte(
      input logic [15:0] value,
      input logic upper
   );
      if (upper) begin
         count_byte = value[15:8]; // RULE_01
      end else begin
         count_byte = value[7:0]; // RULE_01
      end
   endfunction

   // oscillator enable replaces the pin with the shared oscillator
   assign ext_src = ctrl.secondary_osc_enable ? secondary_osc_clock : external_clock_pin; // RULE_04 RULE_05
   // the oscillator request is combined across instances outside this block
   assign secondary_osc_request = ctrl.secondary_osc_enable; // RULE_05

   gtc_edge_sync u_ext (
      .clk(clk),
      .reset(reset),
      .pin(ext_src),
      .bypass(~ctrl.ext_sync_enable), // RULE_08
      .level(ext_level),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   // gate sources are asynchronous, so always resynchronise them
   assign gate_raw = gate_pick(gate_source_select, gate_pin, comp1_out, comp2_out); // RULE_10
   assign gate_in = gate_raw ^ ~gate_polarity;

   gtc_edge_sync u_gate (
      .clk(clk),
      .reset(reset),
      .pin(gate_in),
      .bypass(1'b0),
      .level(gate_level),
      .rise(),
      .fall()
   );

   assign gate_ok = ~ctrl.gate_enable | gate_level; // RULE_03
   assign counting = ctrl.run_enable & gate_ok; // RULE_03
   assign instr_tick = last_phase(st_q.phase); // RULE_06
   // a fresh enable must wait for a new falling edge, whatever the pin did while off
   assign run_rise = ctrl.run_enable & ~st_q.prev_run; // RULE_09
   assign load_any = wr.wr_high | wr.wr_low; // RULE_02
   assign loaded = load_bytes(st_q.count, wr); // RULE_02 RULE_01
   assign step_en = counting & source_step(ctrl.clock_source_select, instr_tick, ext_rise, st_q.armed);

   always_comb begin
      st_d = st_q;
      // the phase runs even while off, so an enable may land at any phase
      st_d.phase = st_q.phase + phase_step;
      // previous run level, used to spot a fresh enable
      st_d.prev_run = ctrl.run_enable;

      st_d.armed = arm_next(st_q.armed, ext_fall, ctrl.run_enable, run_rise, load_any); // RULE_09

      // a write in the same cycle as a step wins; the step is lost, not deferred
      if (load_any) begin
         st_d.count = loaded; // RULE_02
      end else if (step_en) begin
         st_d.count = count_step(st_q.count); // RULE_06 RULE_07 RULE_08
      end
   end

   // one register for all state; reset leaves the counter cleared and disarmed
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q.count <= gtc_pkg::count_reset;
         st_q.phase <= gtc_pkg::phase_reset;
         st_q.armed <= 1'b0;
         st_q.prev_run <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign count_high_byte = count_byte(st_q.count, 1'b1); // RULE_01
   assign count_low_byte = count_byte(st_q.count, 1'b0); // RULE_01
endmodule

// ---- verif/gtc_timer_sva.sv ----
`timescale 1ns/1ns
module gtc_timer_sva #(
   parameter int unsigned width = 16
) (
   input wire logic clk,
   input wire logic reset,
   input gtc_pkg::gtc_ctrl_t ctrl,
   input gtc_pkg::gtc_wr_t wr,
   input wire logic [7:0] count_high_byte,
   input wire logic [7:0] count_low_byte,
   input wire logic secondary_osc_request,
   input wire logic counting
);
   wire [15:0] cnt = {count_high_byte, count_low_byte};
   wire nw = !wr.wr_high && !wr.wr_low;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   osc_request_a: assert property (secondary_osc_request == ctrl.secondary_osc_enable)
      else $error("oscillator request differs from enable");
   off_no_flag_a: assert property (!ctrl.run_enable |-> !counting)
      else $error("counting while run is off");
   always_on_a: assert property (ctrl.run_enable && !ctrl.gate_enable |-> counting)
      else $error("not counting with gate off");
   off_holds_a: assert property (!ctrl.run_enable && nw |=> $stable(cnt))
      else $error("count moved while off");
   high_load_a: assert property (wr.wr_high |=> count_high_byte == $past(wr.wdata))
      else $error("high byte not loaded");
   low_load_a: assert property (wr.wr_low |=> count_low_byte == $past(wr.wdata))
      else $error("low byte not loaded");
   up_only_a: assert property (nw |=> cnt == $past(cnt) || cnt == $past(cnt) + 16'h1)
      else $error("count moved other than up by one");
   sys_step_a: assert property (counting && ctrl.clock_source_select == gtc_pkg::gtc_src_sys && nw
      |=> cnt == $past(cnt) + 16'h1)
      else $error("system clock source missed a step");
   cover property (counting && ctrl.clock_source_select == gtc_pkg::gtc_src_ext);
   cover property (ctrl.gate_enable && ctrl.run_enable && !counting);
   cover property (wr.wr_high ##2 wr.wr_low);
endmodule
bind gtc_timer gtc_timer_sva #(.width(width)) u_sva (.clk(clk), .reset(reset), .ctrl(ctrl), .wr(wr),
   .count_high_byte(count_high_byte), .count_low_byte(count_low_byte),
   .secondary_osc_request(secondary_osc_request), .counting(counting));

// ---- verif/gtc_ext_src.sv ----
`timescale 1ns/1ns
module gtc_ext_src (
   input wire logic clk,
   output logic pin,
   output logic osc
);
   // idles low, so the first rise of a burst has no fall before it
   initial pin = 1'b0;
   assign osc = ~pin;
   task automatic burst(input int n);
      repeat (n) begin
         repeat (4) @(negedge clk);
         pin = 1'b1;
         repeat (4) @(negedge clk);
         pin = 1'b0;
      end
   endtask
endmodule

// ---- verif/test_gtc_timer.sv ----
`timescale 1ns/1ns
`define chk(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module test_gtc_timer;
   logic clk;
   logic reset;
   logic gate;
   logic ep;
   logic osc;
   logic oreq;
   logic [7:0] hi;
   logic [7:0] lo;
   logic on;
   logic c1;
   logic [1:0] gsel;
   gtc_pkg::gtc_ctrl_t ctrl;
   gtc_pkg::gtc_wr_t wr;
   int err_total;
   int comparisons;
   gtc_ext_src u_src (.clk(clk), .pin(ep), .osc(osc));
   gtc_timer dut (.clk(clk), .reset(reset), .ctrl(ctrl), .wr(wr), .external_clock_pin(ep),
      .secondary_osc_clock(osc), .gate_pin(gate), .comp1_out(c1), .comp2_out(1'b0),
      .gate_source_select(gsel), .gate_polarity(1'b1), .count_high_byte(hi),
      .count_low_byte(lo), .secondary_osc_request(oreq), .counting(on));
   task automatic put(input logic h, input logic [7:0] d);
      @(negedge clk) wr = '{h, !h, d};
      @(negedge clk) wr = '0;
   endtask
   task automatic go(input gtc_pkg::gtc_src_t s, input int n);
      @(negedge clk) ctrl.clock_source_select = s;
      ctrl.run_enable = 1'b1;
      repeat (n) @(negedge clk);
      ctrl.run_enable = 1'b0;
   endtask
   task automatic results;
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (6000) @(posedge clk);
      err_total++;
      results;
   end
   initial begin
      ctrl = '0;
      wr = '0;
      gate = 1'b0;
      c1 = 1'b0;
      gsel = 2'h0;
      reset = 1'b1;
      repeat (20) @(negedge clk);
      reset = 1'b0;
      `chk({hi, lo}, 16'h0000)
      put(1'b1, 8'h12);
      put(1'b0, 8'h34);
      `chk({hi, lo}, 16'h1234)
      go(gtc_pkg::gtc_src_sys, 10);
      `chk({hi, lo}, 16'h123e)
      go(gtc_pkg::gtc_src_instr, 40);
      `chk({hi, lo}, 16'h1248)
      go(gtc_pkg::gtc_src_rsvd, 10);
      `chk({hi, lo}, 16'h1248)
      ctrl.gate_enable = 1'b1;
      go(gtc_pkg::gtc_src_sys, 10);
      `chk({hi, lo}, 16'h1248)
      gate = 1'b1;
      repeat (4) @(negedge clk);
      go(gtc_pkg::gtc_src_sys, 10);
      `chk({hi, lo}, 16'h1252)
      gsel = 2'h1;
      c1 = 1'b1;
      gate = 1'b0;
      ctrl.run_enable = 1'b1;
      repeat (4) @(negedge clk);
      `chk(on, 1'b1)
      c1 = 1'b0;
      repeat (4) @(negedge clk);
      `chk(on, 1'b0)
      ctrl.run_enable = 1'b0;
      gsel = 2'h0;
      ctrl.gate_enable = 1'b0;
      for (int s = 1; s >= 0; s--) begin
         ctrl.ext_sync_enable = s[0];
         put(1'b0, 8'h00);
         put(1'b1, 8'h00);
         @(negedge clk) ctrl.clock_source_select = gtc_pkg::gtc_src_ext;
         ctrl.run_enable = 1'b1;
         u_src.burst(5);
         repeat (4) @(negedge clk);
         ctrl.run_enable = 1'b0;
         `chk({hi, lo}, 16'h0004)
      end
      ctrl.secondary_osc_enable = 1'b1;
      @(negedge clk);
      `chk(oreq, 1'b1)
      put(1'b0, 8'h00);
      @(negedge clk) ctrl.clock_source_select = gtc_pkg::gtc_src_ext;
      ctrl.run_enable = 1'b1;
      u_src.burst(5);
      repeat (4) @(negedge clk);
      ctrl.run_enable = 1'b0;
      `chk({hi, lo}, 16'h0005)
      results;
   end
endmodule
